/* File: core/btst_pkg.sv */
// Package of constants and types for the bit test, skip and toggle execution block
package btst_pkg;

    // ----------------------------------------------------------------
    // Instruction encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] BTST_OPC_TOGGLE    = 4'h7;
    localparam logic [3:0] BTST_OPC_SKIP_CLR  = 4'hB;
    localparam logic [3:0] BTST_OPC_SKIP_SET  = 4'hA;
    localparam logic [3:0] BTST_OPC_LONG_HI   = 4'hE;
    localparam logic [2:0] BTST_LONG_SUB      = 3'h6;
    localparam logic [3:0] BTST_OPC_LONG_LO   = 4'hC;
    localparam logic [3:0] BTST_OPC_LONG_MOV  = 4'hF;
    localparam int         BTST_OPC_MSB       = 15;
    localparam int         BTST_OPC_LSB       = 12;
    localparam int         BTST_BIT_MSB       = 11;
    localparam int         BTST_BIT_LSB       = 9;
    localparam int         BTST_ACC_POS       = 8;
    localparam int         BTST_ADR_MSB       = 7;

    // ----------------------------------------------------------------
    // Access bank split and memory shape
    // ----------------------------------------------------------------
    localparam logic [7:0] BTST_ACC_SPLIT     = 8'h80;
    localparam logic [3:0] BTST_ACC_HI_BANK   = 4'hF;
    localparam logic [3:0] BTST_ACC_LO_BANK   = 4'h0;
    localparam int         BTST_MEM_WORDS     = 4096;

    // ----------------------------------------------------------------
    // Q phases and cycle counts
    // ----------------------------------------------------------------
    localparam logic [1:0] BTST_Q_LAST        = 2'h3;
    localparam logic [1:0] BTST_NOP_ONE       = 2'h1;
    localparam logic [1:0] BTST_NOP_TWO       = 2'h2;

    typedef enum logic [3:0] {
        BTST_Q1 = 4'b0001,
        BTST_Q2 = 4'b0010,
        BTST_Q3 = 4'b0100,
        BTST_Q4 = 4'b1000
    } btst_qph_t;

    typedef struct packed {
        logic       valid;
        logic [15:0] word;
        logic [15:0] next_word;
    } btst_instr_t;

    typedef struct packed {
        logic        done;
        logic        skipped;
        logic        toggled;
        logic [11:0] addr;
    } btst_result_t;

endpackage

/* File: core/btst_exec.sv */
// Execution of the skip-if-bit-clear, skip-if-bit-set and bit invert instructions
// Functional notes
// - Skipping a two-word instruction costs two whole no-operation instruction cycles.
// - Skip-if-bit-clear skips when the bit is 0, else runs next normally.
// - Skip-if-bit-set skips when the bit is 1, else continues normally.
// - Bit invert flips bit b of byte f, other bits kept.
// - Bit invert decodes from 0111, three bit index bits, access bit, address.
// - Bit invert changes no status flag.
// - Access bit 0 selects the access bank, ignoring the bank select register.
// - Access bit 1 takes the bank from the bank select register.
// - Skip tests take one cycle, two when skipping, three over two words.
`timescale 1ns/1ns
module btst_exec
    import btst_pkg::*;
(
    // Clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_resetn,
    // Instruction issue
    input  wire btst_instr_t  i_instr,
    input  wire logic [3:0]   i_bank_select_reg,
    input  wire logic [4:0]   i_status,
    // Status, held unchanged by these instructions
    output logic [4:0]        o_status,
    // Per-instruction outcome, one clock in the Q1 after the closing Q4
    output btst_result_t      o_result,
    // Busy while an instruction or its no-operation cycles run
    output logic              o_busy,
    output btst_qph_t         o_qphase
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Opcode nibble of an instruction word
    function automatic logic [3:0] opcode_of(input logic [15:0] w);
        opcode_of = w[BTST_OPC_MSB:BTST_OPC_LSB];
    endfunction

    // Bit index field of an instruction word
    function automatic logic [2:0] bit_of(input logic [15:0] w);
        bit_of = w[BTST_BIT_MSB:BTST_BIT_LSB];
    endfunction

    // Two-word instructions; a skip over one must cover both words
    function automatic logic is_long(input logic [15:0] w);
        logic [3:0] op;
        op = opcode_of(w);
        is_long = (op == BTST_OPC_LONG_LO) ||
                  (op == BTST_OPC_LONG_HI && bit_of(w) == BTST_LONG_SUB);
    endfunction

    // Bank from the access bit; the low half of the access bank is bank 0
    function automatic logic [11:0] eff_addr(input logic [15:0] w, input logic [3:0] bank_select_reg);
        logic [7:0] f;
        f = w[BTST_ADR_MSB:0];
        if (w[BTST_ACC_POS]) begin
            eff_addr = {bank_select_reg, f};
        end else if (f >= BTST_ACC_SPLIT) begin
            eff_addr = {BTST_ACC_HI_BANK, f};
        end else begin
            eff_addr = {BTST_ACC_LO_BANK, f};
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]   mem [BTST_MEM_WORDS];
    btst_qph_t    qph,      next_qph;
    logic         active,   next_active;
    logic [15:0]  cur,      next_cur;
    logic [15:0]  follow,   next_follow;
    logic [11:0]  addr,     next_addr;
    logic [7:0]   data,     next_data;
    logic         skip,     next_skip;
    logic [1:0]   nops,     next_nops;
    logic         wr_en;
    btst_result_t res,      next_res;
    logic         next_busy;

    // ----------------------------------------------------------------
    // Decoded fields of the instruction in flight
    // ----------------------------------------------------------------
    // Decoded once here so the data path and the result agree
    logic [3:0]   cur_op;
    logic [2:0]   sel_bit;
    logic         is_toggle;

    assign cur_op    = opcode_of(cur);
    assign sel_bit   = bit_of(cur);
    assign is_toggle = (cur_op == BTST_OPC_TOGGLE);

    // ----------------------------------------------------------------
    // Instruction sequencer, one edge per Q phase
    // ----------------------------------------------------------------

    always_comb begin
        next_qph    = qph;
        next_active = active;
        next_cur    = cur;
        next_follow = follow;
        next_addr   = addr;
        next_data   = data;
        next_skip   = skip;
        next_nops   = nops;
        next_res    = '0;
        wr_en       = 1'b0;
        case (qph)
            BTST_Q1: begin
                next_qph = BTST_Q2;
                if (nops == '0 && !active && i_instr.valid) begin
                    next_active = 1'b1;
                    next_cur    = i_instr.word;
                    next_follow = i_instr.next_word;
                    next_addr   = eff_addr(i_instr.word, i_bank_select_reg);
                end
            end
            BTST_Q2: begin
                next_qph = BTST_Q3;
                if (active) begin
                    next_data = mem[addr];
                end
            end
            BTST_Q3: begin
                next_qph  = BTST_Q4;
                next_skip = 1'b0;
                if (active) begin
                    case (cur_op)
                        BTST_OPC_TOGGLE:   next_data[sel_bit] = ~data[sel_bit];
                        BTST_OPC_SKIP_CLR: next_skip = ~data[sel_bit];
                        BTST_OPC_SKIP_SET: next_skip = data[sel_bit];
                        default:           next_skip = 1'b0;
                    endcase
                end
            end
            BTST_Q4: begin
                next_qph = BTST_Q1;
                if (active) begin
                    next_active = 1'b0;
                    next_res.done = 1'b1;
                    next_res.addr = addr;
                    if (is_toggle) begin
                        wr_en = 1'b1;
                        next_res.toggled = 1'b1;
                    end
                    // One no-op cycle per word of the skipped instruction
                    if (skip) begin
                        next_res.skipped = 1'b1;
                        next_nops = is_long(follow) ? BTST_NOP_TWO : BTST_NOP_ONE;
                    end
                end else if (nops != '0) begin
                    next_nops = nops - BTST_NOP_ONE;
                end
            end
            default: next_qph = BTST_Q1;
        endcase
        // Busy covers the instruction and any no-op cycles that follow it
        next_busy = next_active || (next_nops != '0);
    end

    // ----------------------------------------------------------------
    // Sequencer registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            qph    <= BTST_Q1;
            active <= 1'b0;
            cur    <= '0;
            follow <= '0;
            addr   <= '0;
            data   <= '0;
            skip   <= 1'b0;
            nops   <= '0;
            res    <= '0;
        end else begin
            qph    <= next_qph;
            active <= next_active;
            cur    <= next_cur;
            follow <= next_follow;
            addr   <= next_addr;
            data   <= next_data;
            skip   <= next_skip;
            nops   <= next_nops;
            res    <= next_res;
        end
    end

    // ----------------------------------------------------------------
    // Data memory
    // ----------------------------------------------------------------
    // Cleared by reset so a bit test after reset reads a known value;
    // the wide clear costs area but keeps unknowns out of the skip decision
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < BTST_MEM_WORDS; i++) begin
                mem[i] <= '0;
            end
        end else if (wr_en) begin
            mem[addr] <= data;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_status <= '0;
            o_result <= '0;
            o_busy   <= 1'b0;
            o_qphase <= BTST_Q1;
        end else begin
            // Straight copy: none of these instructions touches a flag
            o_status <= i_status;
            o_result <= next_res;
            o_busy   <= next_busy;
            o_qphase <= next_qph;
        end
    end

endmodule

/* File: sim/btst_exec_chk.sv */
// Checker of the bit test, skip and invert execution block
`timescale 1ns/1ns
module btst_exec_chk
    import btst_pkg::*;
(
    // Watched ports
    input  wire logic         i_ref_clk,
    input  wire logic         i_resetn,
    input  wire btst_instr_t  i_instr,
    input  wire logic [3:0]   i_bank_select_reg,
    input  wire logic [4:0]   i_status,
    input  wire logic [4:0]   o_status,
    input  wire btst_result_t o_result,
    input  wire logic         o_busy,
    input  wire btst_qph_t    o_qphase
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    logic       take;
    logic [3:0] opc;
    // A take is what the design is offered in Q1 while idle
    assign take = o_qphase == BTST_Q1 && !o_busy && i_instr.valid;
    assign opc  = i_instr.word[15:12];
    a_status_kept: assert property ($past(i_resetn) |-> o_status == $past(i_status))
        else $error("status flags altered");
    a_phase_wrap: assert property (o_qphase == BTST_Q4 |=> o_qphase == BTST_Q1)
        else $error("phase does not wrap to Q1");
    a_toggle_done: assert property (take && opc == BTST_OPC_TOGGLE |-> ##4
        o_result.done && o_result.toggled && !o_result.skipped) else $error("toggle result");
    a_access_low: assert property (take && !i_instr.word[8] && !i_instr.word[7] |-> ##4
        o_result.addr == {BTST_ACC_LO_BANK, $past(i_instr.word[7:0], 4)}) else $error("acc");
    a_bank_sel: assert property (take && i_instr.word[8] |-> ##4
        o_result.addr[11:8] == $past(i_bank_select_reg, 4)) else $error("bank");
    a_skip_done: assert property (take && opc != BTST_OPC_TOGGLE |-> ##4
        o_result.done && !o_result.toggled) else $error("skip result");
    a_done_pulse: assert property (o_result.done |-> o_qphase == BTST_Q1 ##1
        !o_result.done) else $error("done pulse");
    a_skip_nop: assert property (o_result.done && o_result.skipped |-> o_busy ##1
        (!o_result.done) [*7]) else $error("skip without no-op cycle");
endmodule
bind btst_exec btst_exec_chk u_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_instr(i_instr), .i_bank_select_reg(i_bank_select_reg), .i_status(i_status),
    .o_status(o_status), .o_result(o_result), .o_busy(o_busy), .o_qphase(o_qphase));

/* File: sim/btst_exec_tb.sv */
// Self-checking bench of the bit test, skip and invert execution block
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module btst_exec_tb
    import btst_pkg::*;
;
    typedef struct packed {
        btst_result_t r;
        logic [1:0]   m;
        logic         two;
    } btst_note_t;
    logic         i_ref_clk = 1'h0;
    logic         i_resetn = 1'h0;
    btst_instr_t  i_instr = '0;
    logic [3:0]   i_bank_select_reg = 4'h0;
    logic [4:0]   i_status = 5'h00;
    logic [4:0]   o_status;
    btst_result_t o_result;
    logic         o_busy;
    btst_qph_t    o_qphase;
    btst_note_t   notes[$];
    btst_note_t   nt;
    int           num_errors = 0;
    int           num_checks = 0;
    int           gap = 0;
    logic         last = 1'h0;
    logic         prev_sk = 1'h0;
    logic         prev_two = 1'h0;
    logic         have_prev = 1'h0;
    always #25 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) i_status <= 5'($urandom);
    btst_exec dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_instr(i_instr),
        .i_bank_select_reg(i_bank_select_reg), .i_status(i_status), .o_status(o_status),
        .o_result(o_result), .o_busy(o_busy), .o_qphase(o_qphase));
    task automatic complete_run();
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Driver: holds each word until the edge that takes it
    // ----------------------------------------------------------------
    task automatic issue(input logic [3:0] op, input logic [2:0] b, input logic [7:0] f,
                         input logic a, input logic [3:0] k, input logic [15:0] nw,
                         input logic [1:0] m);
        btst_note_t n;
        n.r.done = 1'h1;
        n.r.skipped = 1'h0;
        n.r.toggled = op == BTST_OPC_TOGGLE;
        n.r.addr = a ? {k, f} : {f < BTST_ACC_SPLIT ? BTST_ACC_LO_BANK : BTST_ACC_HI_BANK, f};
        n.m = m;
        n.two = nw[15:12] == BTST_OPC_LONG_LO || nw[15:9] == {BTST_OPC_LONG_HI, BTST_LONG_SUB};
        notes.push_back(n);
        i_instr <= '{1'h1, {op, b, a, f}, nw};
        i_bank_select_reg <= k;
        do @(posedge i_ref_clk); while (!(o_qphase === BTST_Q1 && o_busy === 1'h0));
    endtask
    // ----------------------------------------------------------------
    // Monitor: memory is not visible, so skips are judged in pairs
    // ----------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        gap = gap + 1;
        if (i_resetn && o_result.done === 1'h1) begin
            nt = notes.pop_front();
            `CHK("toggled", nt.r.toggled, o_result.toggled)
            `CHK("addr", nt.r.addr, o_result.addr)
            if (nt.m == 2'h0) `CHK("skip", 1'h0, o_result.skipped)
            if (nt.m == 2'h3) `CHK("skip", ~last, o_result.skipped)
            if (have_prev) `CHK("gap", 4 + (prev_sk ? (prev_two ? 8 : 4) : 0), gap)
            if (nt.m != 2'h0) last = o_result.skipped;
            prev_sk = o_result.skipped;
            prev_two = nt.two;
            have_prev = 1'h1;
            gap = 0;
        end
    end
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
    initial begin
        logic [7:0]  f;
        logic [2:0]  b;
        logic        a;
        logic [3:0]  k;
        logic [15:0] nw;
        void'($urandom(32'h8EF9));
        repeat (12) @(posedge i_ref_clk);
        i_resetn <= 1'h1;
        @(posedge i_ref_clk);
        for (int t = 0; t < 24; t++) begin
            f = 8'($urandom);
            b = 3'($urandom);
            a = 1'($urandom);
            k = 4'($urandom);
            nw = {t % 3 == 0 ? BTST_OPC_LONG_LO : (t % 3 == 1 ? BTST_OPC_LONG_HI : 4'h1),
                  12'($urandom)};
            if (t % 3 == 1) nw[11:9] = BTST_LONG_SUB;
            issue(BTST_OPC_SKIP_CLR, b, f, a, k, nw, 2'h2);
            issue(BTST_OPC_SKIP_SET, b, f, a, k, nw, 2'h3);
            issue(BTST_OPC_TOGGLE, b, f, a, k, nw, 2'h0);
            issue(BTST_OPC_SKIP_SET, b, f, a, k, nw, 2'h3);
        end
        i_instr.valid <= 1'h0;
        repeat (20) @(posedge i_ref_clk);
        `CHK("pending", 0, notes.size())
        complete_run();
    end
endmodule
